// file: rts_pkg.sv
// shared constants and types for the return-to-origin sequencer
package rts_pkg;
  // widths
  localparam int SPD_W = 22;
  localparam int STP_W = 23;
  localparam int FLT_W = 8;
  localparam int TRQ_W = 14;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_START = 8'h04;
  localparam logic [7:0] A_RUN = 8'h08;
  localparam logic [7:0] A_LAST = 8'h0C;
  localparam logic [7:0] A_BACK = 8'h10;
  localparam logic [7:0] A_ONEWAY = 8'h14;
  localparam logic [7:0] A_PRESET = 8'h18;
  localparam logic [7:0] A_OFFSET = 8'h1C;
  localparam logic [7:0] A_FILTER = 8'h20;
  localparam logic [7:0] A_TORQUE = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;
  localparam logic [7:0] A_POS = 8'h2C;
  // control field positions
  localparam int C_MODE = 0;
  localparam int C_DIR = 2;
  localparam int C_SENSOR_INPUT_A = 3;
  localparam int C_ENCZ = 4;
  localparam int C_OPSEL = 6;
  // status field positions
  localparam int S_READY = 3;
  localparam int S_BUSY = 4;
  localparam int S_DONE = 5;
  localparam int S_CV = 6;
  // synchroniser bit positions
  localparam int P_SERVO = 0;
  localparam int P_SEEK = 1;
  localparam int P_LPOS = 2;
  localparam int P_LNEG = 3;
  localparam int P_ORG = 4;
  localparam int P_SENSOR_INPUT_A = 5;
  localparam int P_ENCZ = 6;
  // encodings
  localparam logic [1:0] MODE_2S = 2'h0;
  localparam logic [1:0] MODE_3S = 2'h1;
  localparam logic [1:0] MODE_1W = 2'h2;
  localparam logic [1:0] ENCZ_ON = 2'h2;
  // reset values
  localparam logic [1:0] RST_MODE = 2'h1;
  localparam logic RST_DIR = 1'b1;
  localparam logic RST_OPSEL = 1'b1;
  localparam logic [SPD_W-1:0] RST_START = 22'h0001F4;
  localparam logic [SPD_W-1:0] RST_RUN = 22'h0003E8;
  localparam logic [SPD_W-1:0] RST_LAST = 22'h0001F4;
  localparam logic [STP_W-1:0] RST_STEPS = 23'h0001F4;
  localparam logic [FLT_W-1:0] RST_FILT = 8'h01;
  localparam logic [TRQ_W-1:0] RST_TRQ = 14'h03E8;
  localparam logic [TRQ_W-1:0] TRQ_FULL = 14'h2710;
  // timing
  localparam int CLK_NS = 10;
  localparam int FILT_UNIT_NS = 1000000;
  localparam logic [26:0] CLK_HZ = 27'h5F5E100;
  // sequencer states, gray in the order listed
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_SEEK = 3'h1, ST_REV = 3'h3, ST_LEAVE = 3'h2,
    ST_STEPS = 3'h6, ST_QUAL = 3'h7, ST_OFFS = 3'h5, ST_FIN = 3'h4
  } rts_st_e;
endpackage

// file: rts_step_if.sv
// speed command and step pulse between sequencer and step generator
`timescale 1ns/1ps
interface rts_step_if;
  logic [rts_pkg::SPD_W-1:0] speed;
  logic pulse;
  modport gen (input speed, output pulse);
  modport seq (output speed, input pulse);
endinterface

// file: rts_step_gen.sv
// step pulse generator: phase accumulator at the commanded rate in Hz
`timescale 1ns/1ps
module rts_step_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // speed in, pulse out
  rts_step_if.gen st
);
  typedef struct packed {
    logic [26:0] acc;
    logic pulse;
  } rts_gen_s;
  rts_gen_s s_r, s_nxt;
  logic [27:0] sum;

  // one pulse each time the accumulator passes the clock rate
  always_comb begin
    s_nxt = s_r;
    sum = {1'b0, s_r.acc} + {6'h00, st.speed};
    s_nxt.pulse = 1'b0;
    if (sum >= {1'b0, rts_pkg::CLK_HZ}) begin
      s_nxt.acc = 27'(sum - {1'b0, rts_pkg::CLK_HZ});
      s_nxt.pulse = 1'b1;
    end else begin
      s_nxt.acc = sum[26:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign st.pulse = s_r.pulse;
endmodule

// file: rts_seq.sv
// return-to-origin sequencer with register port and motion outputs
`timescale 1ns/1ps
// Notes on behaviour
// - mode 0/1/2 picks 2-sensor/3-sensor/one-way
// - start direction 0 negative, 1 positive
// - configurable start speed, default 500
// - configurable run speed, default 1000
// - final approach at last speed
// - 2-sensor: backward steps after leaving limit
// - one-way: fixed steps after leaving origin
// - preset loads origin coordinate at completion
// - coordinates invalid throughout the search
// - nonzero offset moved after search
// - sensor_input_a sensor qualifies origin when enabled
// - encoder zero qualifies origin when 2
// - command filter 1 to 200 ms; the filter register takes any 8-bit value, 0 to 255, unchecked
// - torque capped during search
// - selector picks encoder or user settings
// - request drops ready, raises motion
// - 3-sensor: origin on completes search
// - 3-sensor: reverse at limit, stop at origin
// - 2-sensor: reverse, leave limit, back steps
// - qualifiers extend motion until detected
module rts_seq #(
  parameter int MS_CYCLES = rts_pkg::FILT_UNIT_NS / rts_pkg::CLK_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // host handshake
  input wire logic servo_on,
  input wire logic origin_seek_req,
  output logic ready,
  output logic direct_cmd_ready,
  output logic motion_active,
  output logic operation_busy_output,
  output logic return_done,
  output logic coords_valid_output,
  // external sensors
  input wire logic limit_pos,
  input wire logic limit_neg,
  input wire logic origin_sensor_input,
  input wire logic sensor_input_a,
  input wire logic encoder_zero_signal,
  // settings stored in the encoder
  input wire logic [rts_pkg::FLT_W-1:0] enc_filter_ms,
  input wire logic [rts_pkg::TRQ_W-1:0] enc_torque_limit,
  // motion command
  output logic step_pulse,
  output logic step_dir,
  output logic [rts_pkg::SPD_W-1:0] cmd_speed,
  output logic [rts_pkg::TRQ_W-1:0] torque_limit,
  output logic [31:0] position
);
  localparam int SW = rts_pkg::SPD_W;

  typedef struct packed {
    rts_pkg::rts_st_e st;
    logic [6:0] sy1;
    logic [6:0] sy2;
    logic [6:0] prev;
    logic [1:0] mode;
    logic dir_cfg;
    logic sensor_input_a_en;
    logic [1:0] encz_sel;
    logic op_sel;
    logic [SW-1:0] start_spd;
    logic [SW-1:0] run_spd;
    logic [SW-1:0] last_spd;
    logic [rts_pkg::STP_W-1:0] back;
    logic [rts_pkg::STP_W-1:0] oneway;
    logic [31:0] preset;
    logic [31:0] offset;
    logic [rts_pkg::FLT_W-1:0] filt;
    logic [rts_pkg::TRQ_W-1:0] trq;
    logic [31:0] rdata;
    logic [31:0] cnt;
    logic [31:0] pos;
    logic [SW-1:0] spd;
    logic [16:0] ms;
    logic dir;
    logic done;
    logic cv;
  } rts_state_s;

  rts_state_s s_r, s_nxt;
  rts_step_if stp ();

  logic servo, seek_rise, lim_fwd, lim_back, org, org_rise, org_fall;
  logic moving, tick, qual_ok, start;
  logic [SW-1:0] tgt;
  logic [2:0] shift;
  logic [SW:0] diff, dstep;
  logic [rts_pkg::FLT_W-1:0] eff_filt;

  // floor log2 of the filter time gives the smoothing shift
  function automatic logic [2:0] flog2(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------
  // input decode
  // ----------------------------------------------------------
  // every edge detector compares the second sync stage with the stage after it (prev)
  always_comb begin
    servo = s_r.sy2[rts_pkg::P_SERVO];
    seek_rise = s_r.sy2[rts_pkg::P_SEEK] & ~s_r.prev[rts_pkg::P_SEEK];
    org = s_r.sy2[rts_pkg::P_ORG];
    org_rise = org & ~s_r.prev[rts_pkg::P_ORG];
    org_fall = ~org & s_r.prev[rts_pkg::P_ORG];
    lim_fwd = s_r.dir ? s_r.sy2[rts_pkg::P_LPOS] : s_r.sy2[rts_pkg::P_LNEG];
    lim_back = s_r.dir ? s_r.sy2[rts_pkg::P_LNEG] : s_r.sy2[rts_pkg::P_LPOS];
    ready = (s_r.st == rts_pkg::ST_IDLE) & servo;
    start = seek_rise & ready;
    moving = (s_r.st != rts_pkg::ST_IDLE) & (s_r.st != rts_pkg::ST_FIN);
    tick = (s_r.ms == 17'(MS_CYCLES - 1));
    // every enabled qualifier must be present at once
    qual_ok = (~s_r.sensor_input_a_en | s_r.sy2[rts_pkg::P_SENSOR_INPUT_A])
            & ((s_r.encz_sel != rts_pkg::ENCZ_ON) | s_r.sy2[rts_pkg::P_ENCZ])
            & ((s_r.mode != rts_pkg::MODE_3S) | org);
    eff_filt = s_r.op_sel ? s_r.filt : enc_filter_ms;
    shift = flog2(eff_filt);
  end

  // ----------------------------------------------------------
  // target speed per phase
  // ----------------------------------------------------------
  always_comb begin
    case (s_r.st)
      rts_pkg::ST_SEEK: begin
        tgt = (s_r.mode == rts_pkg::MODE_2S) ? s_r.start_spd : s_r.run_spd;
      end
      rts_pkg::ST_REV: begin
        tgt = (s_r.mode == rts_pkg::MODE_2S) ? s_r.last_spd : s_r.run_spd;
      end
      rts_pkg::ST_LEAVE, rts_pkg::ST_QUAL: begin
        tgt = s_r.last_spd;
      end
      rts_pkg::ST_STEPS, rts_pkg::ST_OFFS: begin
        tgt = (s_r.cnt == 32'h0) ? '0 : s_r.start_spd;
      end
      default: begin
        tgt = '0;
      end
    endcase
    diff = (SW+1)'($signed({1'b0, tgt}) - $signed({1'b0, s_r.spd}));
    dstep = (SW+1)'($signed(diff) >>> shift);
  end

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.sy1 = {encoder_zero_signal, sensor_input_a, origin_sensor_input,
                 limit_neg, limit_pos, origin_seek_req, servo_on};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.prev = s_r.sy2;
    s_nxt.rdata = 32'h0;
    s_nxt.ms = tick ? 17'h0 : 17'(s_r.ms + 17'h1);
    // register writes; widths above each field are dropped
    if (reg_wr) begin
      case (reg_addr)
        rts_pkg::A_CTRL: begin
          s_nxt.mode = reg_wdata[rts_pkg::C_MODE +: 2];
          s_nxt.dir_cfg = reg_wdata[rts_pkg::C_DIR];
          s_nxt.sensor_input_a_en = reg_wdata[rts_pkg::C_SENSOR_INPUT_A];
          s_nxt.encz_sel = reg_wdata[rts_pkg::C_ENCZ +: 2];
          s_nxt.op_sel = reg_wdata[rts_pkg::C_OPSEL];
        end
        rts_pkg::A_START: s_nxt.start_spd = reg_wdata[SW-1:0];
        rts_pkg::A_RUN: s_nxt.run_spd = reg_wdata[SW-1:0];
        rts_pkg::A_LAST: s_nxt.last_spd = reg_wdata[SW-1:0];
        rts_pkg::A_BACK: s_nxt.back = reg_wdata[rts_pkg::STP_W-1:0];
        rts_pkg::A_ONEWAY: s_nxt.oneway = reg_wdata[rts_pkg::STP_W-1:0];
        rts_pkg::A_PRESET: s_nxt.preset = reg_wdata;
        rts_pkg::A_OFFSET: s_nxt.offset = reg_wdata;
        rts_pkg::A_FILTER: s_nxt.filt = reg_wdata[rts_pkg::FLT_W-1:0];
        rts_pkg::A_TORQUE: s_nxt.trq = reg_wdata[rts_pkg::TRQ_W-1:0];
        default: begin
        end
      endcase
    end
    // register reads, unmapped offsets answer zero
    if (reg_rd) begin
      case (reg_addr)
        rts_pkg::A_CTRL: begin
          s_nxt.rdata = {25'h0, s_r.op_sel, s_r.encz_sel, s_r.sensor_input_a_en,
                         s_r.dir_cfg, s_r.mode};
        end
        rts_pkg::A_START: s_nxt.rdata = {10'h0, s_r.start_spd};
        rts_pkg::A_RUN: s_nxt.rdata = {10'h0, s_r.run_spd};
        rts_pkg::A_LAST: s_nxt.rdata = {10'h0, s_r.last_spd};
        rts_pkg::A_BACK: s_nxt.rdata = {9'h0, s_r.back};
        rts_pkg::A_ONEWAY: s_nxt.rdata = {9'h0, s_r.oneway};
        rts_pkg::A_PRESET: s_nxt.rdata = s_r.preset;
        rts_pkg::A_OFFSET: s_nxt.rdata = s_r.offset;
        rts_pkg::A_FILTER: s_nxt.rdata = {24'h0, s_r.filt};
        rts_pkg::A_TORQUE: s_nxt.rdata = {18'h0, s_r.trq};
        rts_pkg::A_STATUS: begin
          s_nxt.rdata = {25'h0, s_r.cv, s_r.done, moving, ready, s_r.st};
        end
        rts_pkg::A_POS: s_nxt.rdata = s_r.pos;
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    // command filter: move a 1/2^shift share toward target each ms
    if (tick) begin
      if (dstep == '0) begin
        s_nxt.spd = tgt;
      end else begin
        s_nxt.spd = SW'($signed({1'b0, s_r.spd}) + $signed(dstep));
      end
    end
    // position follows every emitted step
    if (stp.pulse && moving) begin
      s_nxt.pos = s_r.dir ? s_r.pos + 32'h1 : s_r.pos - 32'h1;
      if (s_r.cnt != 32'h0) begin
        s_nxt.cnt = s_r.cnt - 32'h1;
      end
    end
    // search sequence
    case (s_r.st)
      rts_pkg::ST_IDLE: begin
        if (start) begin
          s_nxt.st = rts_pkg::ST_SEEK;
          s_nxt.dir = s_r.dir_cfg;
          s_nxt.done = 1'b0;
          s_nxt.cv = 1'b0;
          s_nxt.spd = '0;
        end
      end
      rts_pkg::ST_SEEK: begin
        if (s_r.mode == rts_pkg::MODE_1W) begin
          if (org_rise) begin
            s_nxt.st = rts_pkg::ST_LEAVE;
          end
        end else if (s_r.mode == rts_pkg::MODE_3S && org_rise) begin
          s_nxt.st = rts_pkg::ST_QUAL;
        end else if (lim_fwd) begin
          s_nxt.dir = ~s_r.dir;
          s_nxt.st = rts_pkg::ST_REV;
        end
      end
      rts_pkg::ST_REV: begin
        if (s_r.mode == rts_pkg::MODE_2S) begin
          // limit now lies behind; wait until it clears
          if (!lim_back) begin
            s_nxt.cnt = {9'h0, s_r.back};
            s_nxt.st = rts_pkg::ST_STEPS;
          end
        end else if (org_rise) begin
          s_nxt.st = rts_pkg::ST_QUAL;
        end
      end
      rts_pkg::ST_LEAVE: begin
        if (org_fall) begin
          s_nxt.cnt = {9'h0, s_r.oneway};
          s_nxt.st = rts_pkg::ST_STEPS;
        end
      end
      rts_pkg::ST_STEPS: begin
        if (s_r.cnt == 32'h0) begin
          s_nxt.st = rts_pkg::ST_QUAL;
        end
      end
      rts_pkg::ST_QUAL: begin
        // with no qualifier enabled this passes in one cycle
        if (qual_ok) begin
          s_nxt.st = rts_pkg::ST_OFFS;
          s_nxt.dir = ~s_r.offset[31];
          s_nxt.cnt = s_r.offset[31] ? 32'(-s_r.offset) : s_r.offset;
        end
      end
      rts_pkg::ST_OFFS: begin
        if (s_r.cnt == 32'h0) begin
          s_nxt.st = rts_pkg::ST_FIN;
        end
      end
      rts_pkg::ST_FIN: begin
        s_nxt.pos = s_r.preset;
        s_nxt.done = 1'b1;
        s_nxt.cv = 1'b1;
        s_nxt.spd = '0;
        s_nxt.st = rts_pkg::ST_IDLE;
      end
      default: begin
        s_nxt.st = rts_pkg::ST_IDLE;
      end
    endcase
    // losing servo aborts; coordinates stay invalid
    if (moving && !servo) begin
      s_nxt.st = rts_pkg::ST_IDLE;
      s_nxt.spd = '0;
    end
  end

  // ----------------------------------------------------------
  // state register
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.st <= rts_pkg::ST_IDLE;
      s_r.mode <= rts_pkg::RST_MODE;
      s_r.dir_cfg <= rts_pkg::RST_DIR;
      s_r.op_sel <= rts_pkg::RST_OPSEL;
      s_r.start_spd <= rts_pkg::RST_START;
      s_r.run_spd <= rts_pkg::RST_RUN;
      s_r.last_spd <= rts_pkg::RST_LAST;
      s_r.back <= rts_pkg::RST_STEPS;
      s_r.oneway <= rts_pkg::RST_STEPS;
      s_r.filt <= rts_pkg::RST_FILT;
      s_r.trq <= rts_pkg::RST_TRQ;
    end else begin
      s_r <= s_nxt;
    end
  end

  // step generator runs only while a phase wants motion
  assign stp.speed = moving && tgt != '0 ? s_r.spd : '0;
  rts_step_gen u_gen (
    .clk(clk),
    .rst_n(rst_n),
    .st(stp.gen)
  );

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign reg_rdata = s_r.rdata;
  assign direct_cmd_ready = ready;
  assign motion_active = moving;
  assign operation_busy_output = moving;
  assign return_done = s_r.done;
  assign coords_valid_output = s_r.cv;
  assign step_pulse = stp.pulse & moving;
  assign step_dir = s_r.dir;
  assign cmd_speed = stp.speed;
  assign position = s_r.pos;
  // the cap only applies during the search
  assign torque_limit = moving ? (s_r.op_sel ? s_r.trq : enc_torque_limit)
                               : rts_pkg::TRQ_FULL;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  start_drop_a: assert property (start |=> motion_active && !ready && !direct_cmd_ready)
    else $error("request did not start search");
  no_start_a: assert property (seek_rise && !servo |=> !motion_active)
    else $error("request taken without servo");
  cv_low_a: assert property (motion_active |-> !coords_valid_output)
    else $error("coordinates valid during search");
  fin_out_a: assert property (s_r.st == rts_pkg::ST_FIN && servo
      |=> return_done && ready && !operation_busy_output)
    else $error("completion outputs wrong");
  preset_a: assert property (s_r.st == rts_pkg::ST_FIN && servo
      |=> position == $past(s_r.preset))
    else $error("preset not loaded");
  dir_start_a: assert property (start |=> step_dir == $past(s_r.dir_cfg))
    else $error("wrong starting direction");
  seek_spd_a: assert property (s_r.st == rts_pkg::ST_SEEK && s_r.mode == rts_pkg::MODE_2S
      |-> tgt == s_r.start_spd)
    else $error("2-sensor seek not at start speed");
  last_spd_a: assert property (s_r.st == rts_pkg::ST_QUAL |-> tgt == s_r.last_spd)
    else $error("approach not at last speed");
  sensor_input_a_hold_a: assert property (s_r.st == rts_pkg::ST_QUAL && s_r.sensor_input_a_en
      && !s_r.sy2[rts_pkg::P_SENSOR_INPUT_A] && servo |=> s_r.st == rts_pkg::ST_QUAL)
    else $error("sensor_input_a qualifier skipped");
  torque_a: assert property (motion_active && s_r.op_sel |-> torque_limit == s_r.trq)
    else $error("torque cap not applied");
  rev_a: assert property (s_r.st == rts_pkg::ST_SEEK && s_r.mode == rts_pkg::MODE_2S
      && lim_fwd && servo |=> s_r.st == rts_pkg::ST_REV && step_dir != $past(step_dir))
    else $error("no reversal at limit");

  three_c: cover property (s_r.st == rts_pkg::ST_QUAL && s_r.mode == rts_pkg::MODE_3S);
  two_c: cover property (s_r.st == rts_pkg::ST_STEPS && s_r.mode == rts_pkg::MODE_2S);
  one_c: cover property (s_r.st == rts_pkg::ST_LEAVE ##[1:1000] s_r.st == rts_pkg::ST_STEPS);
  done_c: cover property ($rose(return_done));
endmodule

// file: rts_mech_model.sv
// shaft and sensor model that stands beyond the sequencer's motion pins
`timescale 1ns/1ps
module rts_mech_model #(
  parameter int ORG_LO = 30,
  parameter int ORG_HI = 40,
  parameter int LIM = 80,
  parameter int SENSOR_INPUT_A_LO = 62,
  parameter int SENSOR_INPUT_A_HI = 66
) (
  // clock
  input wire logic clk,
  // step command from the device
  input wire logic step_pulse,
  input wire logic step_dir,
  // sensor pins
  output logic limit_pos,
  output logic limit_neg,
  output logic origin_sensor_input,
  output logic sensor_input_a,
  output logic encoder_zero_signal,
  // shaft position for the bench
  output int mpos
);
  // ----------------------------------------
  // shaft and sensors
  // ----------------------------------------
  // a device reset does not move the shaft, so no reset here
  initial mpos = 0;
  always @(posedge clk) begin
    if (step_pulse === 1'b1) begin
      mpos <= (step_dir === 1'b1) ? mpos + 1 : mpos - 1;
    end
  end
  // sensors follow shaft position only, with no bounce
  always_comb begin
    limit_pos = (mpos >= LIM);
    limit_neg = (mpos <= -LIM);
    origin_sensor_input = (mpos >= ORG_LO) && (mpos <= ORG_HI);
    sensor_input_a = (mpos >= SENSOR_INPUT_A_LO) && (mpos <= SENSOR_INPUT_A_HI);
    encoder_zero_signal = (mpos % 8 == 0); // one zero mark every 8 steps
  end
endmodule

// file: tb_top.sv
// self-checking bench for the return-to-origin sequencer
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // signals and expected figures
  // ----------------------------------------
  localparam int ORG_LO = 30;
  localparam int ORG_HI = 40;
  localparam int LIM = 80;
  localparam int BACK = 20;
  localparam int OW = 15;
  localparam int OFS = -5;
  localparam logic [31:0] FAST = 32'h003D0900; // 4 MHz: one step per 25 cycles
  localparam logic [31:0] RV [0:9] = '{32'h00000045, 32'(rts_pkg::RST_START),
    32'(rts_pkg::RST_RUN), 32'(rts_pkg::RST_LAST), 32'(rts_pkg::RST_STEPS),
    32'(rts_pkg::RST_STEPS), 32'h00000000, 32'h00000000, 32'(rts_pkg::RST_FILT),
    32'(rts_pkg::RST_TRQ)};
  logic clk, rst_n, reg_wr, reg_rd, servo_on, origin_seek_req;
  logic ready, direct_cmd_ready, motion_active, operation_busy_output, return_done;
  logic coords_valid_output, limit_pos, limit_neg, origin_sensor_input, sensor_input_a;
  logic encoder_zero_signal, step_pulse, step_dir;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, position, rd_v, seed;
  logic [rts_pkg::SPD_W-1:0] cmd_speed;
  logic [rts_pkg::TRQ_W-1:0] torque_limit, enc_trq, exp_trq;
  int err_count, n_tests, mpos;

  rts_seq #(.MS_CYCLES(10)) rts_seq_i (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .servo_on,
    .origin_seek_req, .ready, .direct_cmd_ready, .motion_active, .operation_busy_output,
    .return_done, .coords_valid_output, .limit_pos, .limit_neg, .origin_sensor_input,
    .sensor_input_a, .encoder_zero_signal, .enc_filter_ms(8'h01), .enc_torque_limit(enc_trq),
    .step_pulse, .step_dir, .cmd_speed, .torque_limit, .position
  );
  rts_mech_model #(.ORG_LO(ORG_LO), .ORG_HI(ORG_HI), .LIM(LIM)) rts_mech_model_i (
    .clk, .step_pulse, .step_dir, .limit_pos, .limit_neg, .origin_sensor_input,
    .sensor_input_a, .encoder_zero_signal, .mpos
  );

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  // register master: strobe for exactly one cycle, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask

  // bounded wait on ready, sampled off the edge; running out closes the run
  task automatic wait_ready(input logic v, input int lim);
    #1;
    for (int i = 0; i < lim && ready !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk1("ready level", v, ready);
    if (ready !== v) print_verdict();
  endtask

  // one host-driven search, judged against the shaft model
  task automatic seek(input logic [31:0] ctrl, input logic [31:0] pre, input int mexp);
    int bad, odd, fast;
    bad = 0;
    odd = 0;
    fast = 0;
    wr(rts_pkg::A_CTRL, ctrl);
    wr(rts_pkg::A_PRESET, pre);
    wait_ready(1'b1, 50);
    @(posedge clk);
    origin_seek_req <= 1'b1;
    wait_ready(1'b0, 10);
    chk1("motion", 1'b1, motion_active);
    chk1("cmd ready", 1'b0, direct_cmd_ready);
    chk1("busy", 1'b1, operation_busy_output);
    chk1("done", 1'b0, return_done);
    chk("torque", 32'(exp_trq), 32'(torque_limit));
    // request is held until ready has been seen low
    @(posedge clk);
    origin_seek_req <= 1'b0;
    for (int i = 0; i < 30000 && return_done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      if (return_done !== 1'b1 && coords_valid_output !== 1'b0) bad++;
      // every phase runs at the one programmed rate, or stands still
      if (cmd_speed !== 22'h0 && cmd_speed !== FAST[21:0]) odd++;
      if (cmd_speed === FAST[21:0]) fast++;
    end
    chk1("done", 1'b1, return_done);
    if (return_done !== 1'b1) print_verdict();
    chk("coords low", 32'h0, bad);
    chk1("ready", 1'b1, ready);
    chk1("cmd ready", 1'b1, direct_cmd_ready);
    chk1("motion", 1'b0, motion_active);
    chk1("busy", 1'b0, operation_busy_output);
    chk1("coords", 1'b1, coords_valid_output);
    chk("shaft", mexp, mpos);
    chk("position", pre, position);
    chk("speed steady", 32'h0, odd);
    chk1("speed seen", 1'b1, fast > 0);
    chk("idle speed", 32'h0, 32'(cmd_speed));
    rd(rts_pkg::A_STATUS);
    chk("status", (32'h1 << rts_pkg::S_CV) | (32'h1 << rts_pkg::S_DONE)
        | (32'h1 << rts_pkg::S_READY), rd_v);
    rd(rts_pkg::A_POS);
    chk("position reg", pre, rd_v);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_n, reg_wr, reg_rd, servo_on, origin_seek_req} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    seed = 32'hAD0CE0CC;
    enc_trq = '0;
    exp_trq = rts_pkg::RST_TRQ;
    err_count = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // settings come up at their defaults; a hole reads zero
    for (int i = 0; i < 10; i++) begin
      rd(8'(4 * i));
      chk("reset value", RV[i], rd_v);
    end
    rd(8'h30);
    chk("unmapped", 32'h0, rd_v);
    chk("idle torque", 32'(rts_pkg::TRQ_FULL), 32'(torque_limit));
    // a request while the servo is off must leave the outputs alone
    @(posedge clk);
    origin_seek_req <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk1("motion", 1'b0, motion_active);
    @(posedge clk);
    origin_seek_req <= 1'b0;
    servo_on <= 1'b1;
    // fast speeds and short counts keep the run brief
    wr(rts_pkg::A_START, FAST);
    wr(rts_pkg::A_RUN, FAST);
    wr(rts_pkg::A_LAST, FAST);
    wr(rts_pkg::A_BACK, 32'(BACK));
    wr(rts_pkg::A_ONEWAY, 32'(OW));
    seed = lfsr(seed);
    exp_trq = seed[13:0];
    wr(rts_pkg::A_TORQUE, 32'(exp_trq));
    seed = lfsr(seed);
    seek(32'h00000040, seed, 1 - LIM + BACK);
    wr(rts_pkg::A_OFFSET, 32'(OFS));
    seed = lfsr(seed);
    seek(32'h00000045, seed, ORG_LO + OFS);
    wr(rts_pkg::A_OFFSET, 32'h0);
    seed = lfsr(seed);
    seek(32'h0000006E, seed, 64);
    seed = lfsr(seed);
    @(posedge clk);
    enc_trq <= seed[13:0];
    exp_trq = seed[13:0];
    seed = lfsr(seed);
    seek(32'h00000001, seed, ORG_HI);
    print_verdict();
  end
endmodule
